// File: pkg/timer16_cc_consts.svh
// constants for the timer capture and compare units
`ifndef TIMER16_CC_CONSTS_SVH
`define TIMER16_CC_CONSTS_SVH

// ----------------------------------------
// register offsets on the 8-bit port
// ----------------------------------------
`define ADDR_CTRL_A 8'h00
`define ADDR_CTRL_B 8'h01
`define ADDR_FORCE 8'h02
`define ADDR_CAP_L 8'h06
`define ADDR_CAP_H 8'h07
`define ADDR_CMPA_L 8'h08
`define ADDR_CMPA_H 8'h09
`define ADDR_CMPB_L 8'h0A
`define ADDR_CMPB_H 8'h0B
`define ADDR_IRQ_EN 8'h0C
`define ADDR_FLAGS 8'h0D

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_A_ACT_A_HI 7
`define CTRL_A_ACT_A_LO 6
`define CTRL_A_ACT_B_HI 5
`define CTRL_A_ACT_B_LO 4
`define CTRL_A_MODE_HI 1
`define CTRL_A_MODE_LO 0
`define CTRL_B_FILTER 7
`define CTRL_B_EDGE 6
`define CTRL_B_MODE_HI 4
`define CTRL_B_MODE_LO 3
`define FORCE_A_BIT 7
`define FORCE_B_BIT 6
`define FLAG_CAPTURE 0
`define FLAG_CMP_A 1
`define FLAG_CMP_B 2

// ----------------------------------------
// mode sets, one bit per waveform mode number
// ----------------------------------------
`define MODES_PWM 16'hCFEE
`define MODES_FAST 16'hC0E0
`define MODES_CAPTURE_TOP 16'h5500
`define MODES_UPDATE_AT_TOP 16'h0C0E

// ----------------------------------------
// reset values and filter depth
// ----------------------------------------
`define BYTE_ZERO 8'h00
`define WORD_ZERO 16'h0000
`define FILTER_SAMPLES 4

`endif

// File: pkg/timer16_cc_pkg.sv
// types shared by the capture and compare unit files
`include "timer16_cc_consts.svh"

package timer16_cc_pkg;

  // compare output action encoding
  typedef enum logic [1:0] {ACT_OFF, ACT_TOGGLE, ACT_CLEAR, ACT_SET} compare_action_t;

  // one cycle of the register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // what the counter unit tells the channels
  typedef struct packed {
    logic [15:0] value;
    logic tick;
    logic at_top;
    logic at_bottom;
    logic counting_down;
    logic written;
  } counter_view_t;

  // state of the noise filter
  typedef struct packed {
    logic [`FILTER_SAMPLES-1:0] history;
    logic stable;
  } filter_state_t;

  // state of the whole unit
  typedef struct packed {
    logic [1:0][1:0] action;
    logic [3:0] mode;
    logic filter_en;
    logic edge_rise;
    logic [7:0] high_latch;
    logic [15:0] capture_value;
    logic [1:0][15:0] compare_value;
    logic [1:0][15:0] compare_buffer;
    logic [1:0] compare_output_bit;
    logic [1:0] compare_flag;
    logic capture_flag;
    logic [1:0] compare_irq_enable;
    logic capture_irq_enable;
    logic match_block;
    logic prev_level;
    logic [7:0] rd_data;
  } unit_state_t;

endpackage

// File: test/pin_partner.sv
// pad-side model: capture event source and pull-up load on compare pads
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
  // clock
  input wire logic clock,
  // event level asked for by the bench
  input wire logic level_req,
  // capture pad
  output logic capture_input_pin,
  // compare pads as driven by the unit
  input wire logic [1:0] compare_pin_out,
  input wire logic [1:0] compare_pin_oe,
  // level really seen on the compare pads
  output logic [1:0] pad_level
);
  // ----------------------------------------
  // event source
  // ----------------------------------------
  // moves just after the edge, like a synchronous external driver
  initial capture_input_pin = 1'h0;
  always @(posedge clock) begin
    capture_input_pin <= level_req;
  end

  // ----------------------------------------
  // pad resolution
  // ----------------------------------------
  // an undriven pad rises through its pull-up, so stale data never shows
  assign pad_level = (compare_pin_out & compare_pin_oe) | ~compare_pin_oe;
endmodule
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the timer capture and compare units
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cc_consts.svh"

// one comparison: counted, and a mismatch reported at once
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module tb
  import timer16_cc_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct {logic w; logic [7:0] a; logic [7:0] d;} row_t;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  bus_req_t bus = '0;
  logic [7:0] read_data;
  counter_view_t cnt = '0;
  logic capture_input_pin;
  logic level_req = 1'h0;
  logic capture_port_out = 1'h0;
  logic capture_port_dir = 1'h0;
  logic [1:0] port_out_bits = 2'h3;
  logic [1:0] output_pin_direction_bit = 2'h1; // only A driven, B left to pull-up
  logic [1:0] compare_pin_out;
  logic [1:0] compare_pin_oe;
  logic [1:0] pad_level;
  logic capture_irq;
  logic [1:0] compare_irq;
  logic capture_irq_ack = 1'h0;
  logic [1:0] compare_irq_ack = 2'h0;
  logic [15:0] compare_a_top;
  logic [15:0] capture_top;
  logic [7:0] q; // last read byte
  int errors = 0;
  int compares = 0;
  int n0; // unfiltered detect delay
  int n1; // filtered detect delay
  int n;
  // ordinary register traffic: write, or read with the byte expected
  row_t rows [12] = '{
    '{1'h1, `ADDR_CMPA_H, 8'h12}, '{1'h1, `ADDR_CMPA_L, 8'h34},
    '{1'h0, `ADDR_CMPA_L, 8'h34}, '{1'h0, `ADDR_CMPA_H, 8'h12},
    '{1'h1, `ADDR_CMPB_H, 8'hAB}, '{1'h1, `ADDR_CMPB_L, 8'hCD},
    '{1'h0, `ADDR_CMPB_H, 8'hAB}, '{1'h0, `ADDR_CMPB_L, 8'hCD},
    '{1'h0, 8'h03, 8'h00}, '{1'h0, `ADDR_FLAGS, 8'h00},
    '{1'h1, `ADDR_CTRL_A, 8'hC0}, '{1'h0, `ADDR_CTRL_A, 8'hC0}};

  timer16_capture_compare_units dut (
    .clock(clock), .reset_n(reset_n), .bus(bus), .read_data(read_data),
    .counter_in(cnt), .capture_input_pin(capture_input_pin),
    .capture_port_out(capture_port_out), .capture_port_dir(capture_port_dir),
    .port_out_bits(port_out_bits), .output_pin_direction_bit(output_pin_direction_bit),
    .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe),
    .capture_irq(capture_irq), .compare_irq(compare_irq),
    .capture_irq_ack(capture_irq_ack), .compare_irq_ack(compare_irq_ack),
    .compare_a_top(compare_a_top), .capture_top(capture_top));

  pin_partner partner (
    .clock(clock), .level_req(level_req), .capture_input_pin(capture_input_pin),
    .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe),
    .pad_level(pad_level));

  // 20 MHz system clock
  always #25 clock = ~clock;

  // ----------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clock);
    bus <= '0;
  endtask

  // one-cycle read strobe; data is only valid in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clock);
    bus <= '0;
    @(negedge clock);
    v = read_data;
  endtask

  // one timer tick, with top and counter-write indications
  task automatic tick(input logic [15:0] v, input logic top, input logic wrt);
    @(posedge clock);
    cnt <= '{value: v, tick: 1'h1, at_top: top, at_bottom: 1'h0,
             counting_down: 1'h0, written: wrt};
    @(posedge clock);
    cnt <= '{value: v, tick: 1'h0, at_top: 1'h0, at_bottom: 1'h0,
             counting_down: 1'h0, written: 1'h0};
    @(negedge clock);
  endtask

  // move the event source, count cycles until the capture shows (bounded)
  task automatic edge_time(input logic lvl, input logic via_port, output int cyc);
    @(posedge clock);
    if (via_port) begin
      capture_port_out <= lvl;
    end else begin
      level_req <= lvl;
    end
    cyc = 0;
    while (cyc < 20) begin
      @(negedge clock);
      if (capture_irq === 1'h1) break;
      cyc++;
    end
  endtask

  // verdict and end of run
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // watchdog: the tests need well under 1000 cycles
  // ----------------------------------------
  initial begin
    repeat (3000) @(posedge clock);
    errors++;
    end_sim();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    `CHK("reset read", 8'h00, read_data)
    `CHK("reset pins", port_out_bits, compare_pin_out)
    `CHK("reset irq", 1'h0, capture_irq)
    reset_n <= 1'h1;
    // table of plain register traffic
    for (int i = 0; i < 12; i++) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a, q);
        `CHK("row read", rows[i].d, q)
      end
    end
    // compare A direct in normal mode, output bit zero overrides port A
    `CHK("top direct", 16'h1234, compare_a_top)
    `CHK("pin override", 2'h2, compare_pin_out)
    `CHK("pad level", 2'h2, pad_level)
    `CHK("pin enable", 2'h1, compare_pin_oe)
    // force sets the bit but no flag
    wr(`ADDR_FORCE, 8'h80);
    @(negedge clock);
    `CHK("forced pin", 1'h1, compare_pin_out[0])
    rd(`ADDR_FLAGS, q);
    `CHK("force flag", 8'h00, q)
    // counter write blocks the following tick's match only
    wr(`ADDR_IRQ_EN, 8'h02);
    tick(16'h0000, 1'h0, 1'h1);
    tick(16'h1234, 1'h0, 1'h0);
    `CHK("blocked match", 2'h0, compare_irq)
    tick(16'h1234, 1'h0, 1'h0);
    `CHK("match irq", 2'h1, compare_irq)
    @(posedge clock);
    compare_irq_ack <= 2'h1;
    @(posedge clock);
    compare_irq_ack <= 2'h0;
    @(negedge clock);
    `CHK("ack clear", 2'h0, compare_irq)
    tick(16'h1234, 1'h0, 1'h0);
    `CHK("match again", 2'h1, compare_irq)
    wr(`ADDR_FLAGS, 8'h02);
    @(negedge clock);
    `CHK("write-one clear", 2'h0, compare_irq)
    // action off at once gives the port back; bit survives a mode change
    wr(`ADDR_CTRL_A, 8'h00);
    @(negedge clock);
    `CHK("action off", 2'h3, compare_pin_out)
    wr(`ADDR_CTRL_A, 8'hC1);
    @(negedge clock);
    `CHK("bit kept", 1'h1, compare_pin_out[0])
    // pwm mode: writes land in the buffer until top
    wr(`ADDR_CMPA_H, 8'h56);
    wr(`ADDR_CMPA_L, 8'h78);
    @(negedge clock);
    `CHK("buffered", 16'h1234, compare_a_top)
    tick(16'h0000, 1'h1, 1'h0);
    `CHK("loaded at top", 16'h5678, compare_a_top)
    wr(`ADDR_CTRL_A, 8'hC0);
    // capture, rising edge, no filter, with the compare A action active
    wr(`ADDR_IRQ_EN, 8'h01);
    wr(`ADDR_CTRL_B, 8'h40);
    @(posedge clock);
    cnt.value <= 16'h0A0B;
    edge_time(1'h1, 1'h0, n0);
    `CHK("capture", 1'h1, capture_irq)
    rd(`ADDR_CAP_L, q);
    `CHK("cap low", 8'h0B, q)
    rd(`ADDR_CAP_H, q);
    `CHK("cap high", 8'h0A, q)
    // flip edge, then clear the flag
    wr(`ADDR_CTRL_B, 8'h00);
    wr(`ADDR_FLAGS, 8'h01);
    @(negedge clock);
    `CHK("cap clear", 1'h0, capture_irq)
    @(posedge clock);
    cnt.value <= 16'h0C0D;
    edge_time(1'h0, 1'h0, n);
    `CHK("overwrite", 16'h0C0D, capture_top)
    // filter adds exactly four cycles
    wr(`ADDR_CTRL_B, 8'hC0);
    wr(`ADDR_FLAGS, 8'h01);
    edge_time(1'h1, 1'h0, n1);
    `CHK("filter delay", 32'h4, n1 - n0)
    // three-sample low glitch must not pass the filter
    wr(`ADDR_CTRL_B, 8'h80);
    wr(`ADDR_FLAGS, 8'h01);
    @(posedge clock);
    level_req <= 1'h0;
    repeat (3) @(posedge clock);
    level_req <= 1'h1;
    repeat (12) @(posedge clock);
    @(negedge clock);
    `CHK("glitch", 1'h0, capture_irq)
    // software capture through the port bit
    wr(`ADDR_CTRL_B, 8'h40);
    wr(`ADDR_FLAGS, 8'h01);
    @(posedge clock);
    capture_port_dir <= 1'h1;
    edge_time(1'h1, 1'h1, n);
    `CHK("port capture", 1'h1, capture_irq)
    // interrupt execution clears the capture flag
    @(posedge clock);
    capture_irq_ack <= 1'h1;
    @(posedge clock);
    capture_irq_ack <= 1'h0;
    @(negedge clock);
    `CHK("cap ack", 1'h0, capture_irq)
    // capture input off while capture sets top
    wr(`ADDR_CTRL_B, 8'h58);
    wr(`ADDR_FLAGS, 8'h01);
    @(posedge clock);
    capture_port_out <= 1'h0;
    repeat (8) @(posedge clock);
    edge_time(1'h1, 1'h1, n);
    `CHK("top mode", 1'h0, capture_irq)
    end_sim();
  end
endmodule
`default_nettype wire

// File: verilog/capture_filter.sv
// noise filter ahead of the capture edge detector
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cc_consts.svh"

module capture_filter
  import timer16_cc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // sample input and control
  input wire logic sample_in,
  input wire logic filter_enable,
  // level for the edge detector
  output logic level_out
);

  filter_state_t s_r; // registered state
  filter_state_t s_nxt; // next state

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // samples run on the system clock, so the prescaler never slows them
  always_comb begin
    s_nxt = s_r;
    s_nxt.history = {s_r.history[`FILTER_SAMPLES-2:0], sample_in};
    // output moves only on a full run of equal samples
    if (&s_r.history) begin
      s_nxt.stable = 1'b1;
    end else if (~|s_r.history) begin
      s_nxt.stable = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // filtered level lags the plain sample by four clocks
  assign level_out = filter_enable ? s_r.stable : s_r.history[0];

  a_filter_run_equal: assert property (
    @(posedge clock) disable iff (!reset_n)
    (s_r.stable != $past(s_r.stable)) |-> ($past(&s_r.history) || $past(~|s_r.history))
  ) else $error("filter output moved without four equal samples");

endmodule
`default_nettype wire

// File: verilog/timer16_capture_compare_units.sv
// input capture front end and compare channels of a 16-bit timer
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cc_consts.svh"

module timer16_capture_compare_units
  import timer16_cc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire bus_req_t bus,
  output logic [7:0] read_data,
  // counter unit view
  input wire counter_view_t counter_in,
  // capture pin and its port bits
  input wire logic capture_input_pin,
  input wire logic capture_port_out,
  input wire logic capture_port_dir,
  // compare pins and their port bits
  input wire logic [1:0] port_out_bits,
  input wire logic [1:0] output_pin_direction_bit,
  output logic [1:0] compare_pin_out,
  output logic [1:0] compare_pin_oe,
  // interrupt requests and acknowledges
  output logic capture_irq,
  output logic [1:0] compare_irq,
  input wire logic capture_irq_ack,
  input wire logic [1:0] compare_irq_ack,
  // values offered to the counter unit as top
  output logic [15:0] compare_a_top,
  output logic [15:0] capture_top
);

  unit_state_t s_r; // registered state
  unit_state_t s_nxt; // next state

  logic pwm_mode; // double buffering active
  logic fast_mode; // single slope pwm
  logic capture_top_mode; // capture value sets top
  logic buffer_load; // buffer to compare transfer point
  logic pin_level; // level entering the filter
  logic filtered; // filter or plain sample output
  logic capture_edge; // qualified capture event
  logic [1:0] hit; // comparator match on a tick
  logic [1:0] force_now; // accepted force strobes
  logic [2:0] flag_clear; // write-one clears of the flags

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // one-hot pick of the mode bit keeps each decode exactly one bit wide
  assign pwm_mode = |(`MODES_PWM & (16'h0001 << s_r.mode));
  assign fast_mode = |(`MODES_FAST & (16'h0001 << s_r.mode));
  assign capture_top_mode = |(`MODES_CAPTURE_TOP & (16'h0001 << s_r.mode));
  // phase correct loads at top, the others at bottom
  assign buffer_load = counter_in.tick && pwm_mode &&
    (|(`MODES_UPDATE_AT_TOP & (16'h0001 << s_r.mode)) ? counter_in.at_top
                                                      : counter_in.at_bottom);

  // ----------------------------------------
  // capture front end
  // ----------------------------------------
  // a driven port replaces the pad, so software can fire a capture
  assign pin_level = capture_port_dir ? capture_port_out : capture_input_pin;

  capture_filter filter_u (
    .clock(clock),
    .reset_n(reset_n),
    .sample_in(pin_level),
    .filter_enable(s_r.filter_en),
    .level_out(filtered)
  );

  // edge detector; the action bits play no part here
  assign capture_edge = !capture_top_mode && (filtered != s_r.prev_level) &&
    (filtered == s_r.edge_rise);

  // ----------------------------------------
  // comparators and force strobes
  // ----------------------------------------
  // matches seen while a counter write is pending are dropped
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      hit[ch] = counter_in.tick && !s_r.match_block &&
        (counter_in.value == s_r.compare_value[ch]);
    end
    force_now[0] = bus.wr && bus.addr == `ADDR_FORCE && bus.wdata[`FORCE_A_BIT] && !pwm_mode;
    force_now[1] = bus.wr && bus.addr == `ADDR_FORCE && bus.wdata[`FORCE_B_BIT] && !pwm_mode;
    flag_clear = (bus.wr && bus.addr == `ADDR_FLAGS) ? bus.wdata[2:0] : 3'h0;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_data = `BYTE_ZERO; // read data stands one cycle only
    s_nxt.prev_level = filtered;
    // counter write arms blocking, the next tick spends it
    if (counter_in.written) begin
      s_nxt.match_block = 1'b1;
    end else if (counter_in.tick) begin
      s_nxt.match_block = 1'b0;
    end
    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        `ADDR_CTRL_A: begin
          s_nxt.action[0] = bus.wdata[`CTRL_A_ACT_A_HI:`CTRL_A_ACT_A_LO];
          s_nxt.action[1] = bus.wdata[`CTRL_A_ACT_B_HI:`CTRL_A_ACT_B_LO];
          s_nxt.mode[1:0] = bus.wdata[`CTRL_A_MODE_HI:`CTRL_A_MODE_LO];
        end
        `ADDR_CTRL_B: begin
          s_nxt.filter_en = bus.wdata[`CTRL_B_FILTER];
          s_nxt.edge_rise = bus.wdata[`CTRL_B_EDGE];
          s_nxt.mode[3:2] = bus.wdata[`CTRL_B_MODE_HI:`CTRL_B_MODE_LO];
        end
        // every high byte goes through the one shared latch
        `ADDR_CAP_H, `ADDR_CMPA_H, `ADDR_CMPB_H: begin
          s_nxt.high_latch = bus.wdata;
        end
        `ADDR_CAP_L: begin
          // writable only while it defines top
          if (capture_top_mode) begin
            s_nxt.capture_value = {s_r.high_latch, bus.wdata};
          end
        end
        `ADDR_CMPA_L, `ADDR_CMPB_L: begin
          if (pwm_mode) begin
            s_nxt.compare_buffer[bus.addr[1]] = {s_r.high_latch, bus.wdata};
          end else begin
            s_nxt.compare_value[bus.addr[1]] = {s_r.high_latch, bus.wdata};
          end
        end
        `ADDR_IRQ_EN: begin
          s_nxt.capture_irq_enable = bus.wdata[`FLAG_CAPTURE];
          s_nxt.compare_irq_enable = bus.wdata[`FLAG_CMP_B:`FLAG_CMP_A];
        end
        default: begin
          // force and flag writes act through their own terms
        end
      endcase
    end
    // register reads, answered on the next cycle
    if (bus.rd) begin
      unique case (bus.addr)
        `ADDR_CTRL_A: s_nxt.rd_data = {s_r.action[0], s_r.action[1], 2'h0, s_r.mode[1:0]};
        `ADDR_CTRL_B: s_nxt.rd_data = {s_r.filter_en, s_r.edge_rise, 1'b0,
                                       s_r.mode[3:2], 3'h0};
        `ADDR_CAP_L: begin
          // low read freezes the high byte for the next read
          s_nxt.rd_data = s_r.capture_value[7:0];
          s_nxt.high_latch = s_r.capture_value[15:8];
        end
        `ADDR_CAP_H: s_nxt.rd_data = s_r.high_latch;
        // compare registers read straight, bypassing the latch
        `ADDR_CMPA_L, `ADDR_CMPB_L: s_nxt.rd_data = pwm_mode ?
          s_r.compare_buffer[bus.addr[1]][7:0] : s_r.compare_value[bus.addr[1]][7:0];
        `ADDR_CMPA_H, `ADDR_CMPB_H: s_nxt.rd_data = pwm_mode ?
          s_r.compare_buffer[bus.addr[1]][15:8] : s_r.compare_value[bus.addr[1]][15:8];
        `ADDR_IRQ_EN: s_nxt.rd_data = {5'h00, s_r.compare_irq_enable, s_r.capture_irq_enable};
        `ADDR_FLAGS: s_nxt.rd_data = {5'h00, s_r.compare_flag, s_r.capture_flag};
        default: s_nxt.rd_data = `BYTE_ZERO;
      endcase
    end
    // capture: copy and flag in the same clock, old value lost
    s_nxt.capture_flag = s_r.capture_flag &&
      !(flag_clear[`FLAG_CAPTURE] || capture_irq_ack);
    if (capture_edge) begin
      s_nxt.capture_value = counter_in.value;
      s_nxt.capture_flag = 1'b1;
    end
    // compare channels
    for (int ch = 0; ch < 2; ch++) begin
      // set beats clear when both land together
      s_nxt.compare_flag[ch] = (s_r.compare_flag[ch] &&
        !(flag_clear[`FLAG_CMP_A + ch] || compare_irq_ack[ch])) || hit[ch];
      if (buffer_load) begin
        s_nxt.compare_value[ch] = s_r.compare_buffer[ch];
      end
      // waveform generator
      if (!pwm_mode) begin
        if (hit[ch] || force_now[ch]) begin
          unique case (compare_action_t'(s_r.action[ch]))
            ACT_OFF: s_nxt.compare_output_bit[ch] = s_r.compare_output_bit[ch];
            ACT_TOGGLE: s_nxt.compare_output_bit[ch] = !s_r.compare_output_bit[ch];
            ACT_CLEAR: s_nxt.compare_output_bit[ch] = 1'b0;
            ACT_SET: s_nxt.compare_output_bit[ch] = 1'b1;
          endcase
        end
      end else if (s_r.action[ch][1]) begin
        // single slope: match sets one level, bottom the other
        if (fast_mode && hit[ch]) begin
          s_nxt.compare_output_bit[ch] = s_r.action[ch][0];
        end else if (fast_mode && counter_in.tick && counter_in.at_bottom) begin
          s_nxt.compare_output_bit[ch] = !s_r.action[ch][0];
        end else if (!fast_mode && hit[ch]) begin
          // dual slope: level follows the count direction
          s_nxt.compare_output_bit[ch] = s_r.action[ch][0] ^ counter_in.counting_down;
        end
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // output bits clear here on reset or through the waveform generator; a mode change leaves them alone
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign read_data = s_r.rd_data;
  assign compare_a_top = s_r.compare_value[0];
  assign capture_top = s_r.capture_value;
  assign capture_irq = s_r.capture_flag && s_r.capture_irq_enable;
  assign compare_irq = s_r.compare_flag & s_r.compare_irq_enable;
  // pin shows the channel bit whenever its action is not off; the direction bit only sets the enable
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      compare_pin_out[ch] = (s_r.action[ch] != 2'h0) ? s_r.compare_output_bit[ch]
                                                     : port_out_bits[ch];
      compare_pin_oe[ch] = output_pin_direction_bit[ch];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_capture_copy: assert property (
    @(posedge clock) disable iff (!reset_n)
    capture_edge |=> (s_r.capture_value == $past(counter_in.value)) && s_r.capture_flag
  ) else $error("capture did not copy counter and set flag");

  a_capture_top_off: assert property (
    @(posedge clock) disable iff (!reset_n)
    (capture_top_mode && !s_r.capture_flag) |=> !s_r.capture_flag
  ) else $error("capture flag set while capture defines top");

  a_match_sets_flag: assert property (
    @(posedge clock) disable iff (!reset_n)
    (counter_in.tick && !s_r.match_block && counter_in.value == s_r.compare_value[0])
      |=> s_r.compare_flag[0]
  ) else $error("match on channel a did not set its flag");

  a_write_blocks_match: assert property (
    @(posedge clock) disable iff (!reset_n)
    (counter_in.written ##1 (!counter_in.tick && !counter_in.written)
      ##1 (counter_in.tick && s_r.compare_flag == 2'h0))
      |=> s_r.compare_flag == 2'h0
  ) else $error("match after counter write was not blocked");

  a_ack_clears_flag: assert property (
    @(posedge clock) disable iff (!reset_n)
    (compare_irq_ack[0] && !hit[0]) |=> !s_r.compare_flag[0] && !compare_irq[0]
  ) else $error("acknowledge did not clear channel a flag");

  a_force_no_flag: assert property (
    @(posedge clock) disable iff (!reset_n)
    (force_now[0] && !hit[0] && !s_r.compare_flag[0] && s_r.action[0] == 2'h3)
      |=> !s_r.compare_flag[0] && s_r.compare_output_bit[0]
  ) else $error("force strobe misbehaved on channel a");

  a_direct_write: assert property (
    @(posedge clock) disable iff (!reset_n)
    (bus.wr && bus.addr == `ADDR_CMPB_L && !pwm_mode && !buffer_load)
      |=> s_r.compare_value[1] == {$past(s_r.high_latch), $past(bus.wdata)}
  ) else $error("direct compare write did not join latch and low byte");

  a_buffer_holds: assert property (
    @(posedge clock) disable iff (!reset_n)
    (pwm_mode && bus.wr && bus.addr == `ADDR_CMPA_L && !buffer_load)
      |=> s_r.compare_value[0] == $past(s_r.compare_value[0])
  ) else $error("buffered compare changed before its load point");

  a_compare_read: assert property (
    @(posedge clock) disable iff (!reset_n)
    (bus.rd && bus.addr == `ADDR_CMPA_H && !pwm_mode)
      |=> read_data == $past(s_r.compare_value[0][15:8])
      ##1 (read_data == `BYTE_ZERO || $past(bus.rd))
  ) else $error("compare high read did not return the register directly");

  a_pin_override: assert property (
    @(posedge clock) disable iff (!reset_n)
    (s_r.action[0] != 2'h0) |-> compare_pin_out[0] == s_r.compare_output_bit[0]
  ) else $error("channel a did not override the port value");

endmodule
`default_nettype wire
